// ==== design/cirm_top.sv ====
// Design decisions made here: the register offsets and the APB interface to the registers.
`default_nettype none
module cirm_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     can_rx,
  input  wire cirm_pkg::cirm_frame_type rx_frame,
  input  wire logic                     rx_valid,
  input  wire logic                     frame_edge,
  input  wire cirm_pkg::cirm_errev_type err_ev,
  input  wire logic                     tx_pending,
  output logic                          can_active,
  output logic                          proto_reset,
  output logic [31:0]                   bit_timing,
  output logic                          can_irq
);
  import cirm_pkg::*;

  typedef struct packed {
    logic              en;
    logic              autobaud_listen_bit;
    logic              lpm;
    logic [31:0]       imr;
    logic [31:0]       bittime;
    logic [15:0]       timer;
    logic [15:0]       tstamp;
    logic [8:0]        tec;
    logic [7:0]        rec;
    logic              sleep;
    logic              wake;
    logic              tovf;
    logic              tstp;
    logic              hunt;
    cirm_mbox_arr_type mb;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              proto_rst;
  } cirm_state_type;

  cirm_state_type        q;
  cirm_state_type        n;
  logic                  acc_first;
  logic                  wr_cyc;
  logic                  rd_cyc;
  logic                  mb_hit;
  logic [2:0]            mb_off;
  logic [MB_IDX_W-1:0]   mb_idx;
  logic [4:0]            mb_sub;
  logic                  mapped;
  logic [31:0]           rdata;
  logic [31:0]           status;
  logic                  erra;
  logic                  errp;
  logic                  boff;
  logic                  warn;
  logic                  bit_tick;
  logic                  sync_pulse;
  logic                  rx_take;
  logic                  acc_hit;
  logic [MB_IDX_W-1:0]   acc_idx;
  logic [NUM_MB-1:0]     ready_vec;

  function automatic logic [8:0] sat_step(input logic [8:0] c, input logic [8:0] top,
                                          input logic inc, input logic dec);
    if (inc && c != top) begin
      return c + 9'h001;
    end else if (dec && !inc && c != 9'h000) begin
      return c - 9'h001;
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // Leaf blocks
  // ------------------------------------------------------------
  cirm_bus_sync u_sync (
    .pclk       (pclk),
    .presetn    (presetn),
    .can_rx     (can_rx),
    .bit_cycles (q.bittime[15:0]),
    .hunt       (q.hunt & q.en & !q.lpm),
    .bit_tick   (bit_tick),
    .synced     (sync_pulse)
  );

  assign rx_take = rx_valid & q.en & q.wake & !q.sleep;

  cirm_accept u_accept (
    .mbx    (q.mb),
    .rx_id  (rx_frame.id),
    .active (rx_take),
    .hit    (acc_hit),
    .idx    (acc_idx)
  );

  // ------------------------------------------------------------
  // Error state and status word
  // ------------------------------------------------------------
  always_comb begin
    errp   = (q.tec >= PASS_LIMIT) || ({1'b0, q.rec} >= PASS_LIMIT);
    boff   = q.tec[8];
    erra   = !errp;
    warn   = erra && ((q.tec > WARN_LIMIT) || ({1'b0, q.rec} > WARN_LIMIT));
    status = '0;
    for (int i = 0; i < NUM_MB; i++) begin
      ready_vec[i] = q.mb[i].ready;
    end
    status[NUM_MB-1:0] = ready_vec;
    status[ST_ERRA]    = erra;
    status[ST_WARN]    = warn;
    status[ST_ERRP]    = errp;
    status[ST_BOFF]    = boff;
    status[ST_SLEEP]   = q.sleep;
    status[ST_WAKE]    = q.wake;
    status[ST_TOVF]    = q.tovf;
    status[ST_TSTP]    = q.tstp;
  end

  // ------------------------------------------------------------
  // APB decode and read mux
  // ------------------------------------------------------------
  assign acc_first = psel & penable & !q.pready;
  assign wr_cyc    = acc_first & pwrite;
  assign rd_cyc    = acc_first & !pwrite;
  assign mb_off    = paddr[7:5] - MB_FIRST;
  assign mb_idx    = mb_off[MB_IDX_W-1:0];
  assign mb_sub    = paddr[4:0];
  assign mb_hit    = (paddr[7:5] >= MB_FIRST) && (paddr[7:5] <= MB_LAST) && (mb_sub <= MB_CTRL) &&
                     (paddr[1:0] == 2'h0);

  always_comb begin
    rdata  = '0;
    mapped = 1'b1;
    case (paddr)
      A_MODE: begin
        rdata[MODE_EN_BIT]  = q.en;
        rdata[MODE_ABM_BIT] = q.autobaud_listen_bit;
        rdata[MODE_LPM_BIT] = q.lpm;
      end
      A_IER, A_IDR: rdata = '0;
      A_IMR:        rdata = q.imr;
      A_STATUS:     rdata = status;
      A_BITTIME:    rdata = q.bittime;
      A_TIMER:      rdata = {16'h0000, q.timer};
      A_TSTAMP:     rdata = {16'h0000, q.tstamp};
      A_ERRCNT:     rdata = {7'h00, q.tec, 8'h00, q.rec};
      default: begin
        if (mb_hit) begin
          case (mb_sub)
            MB_MODE: begin
              rdata[MBM_OT_LSB +: 3] = q.mb[mb_idx].otype;
              rdata[MBM_PR_LSB +: 4] = q.mb[mb_idx].prio;
            end
            MB_MASK: rdata[ID_W-1:0] = q.mb[mb_idx].mask;
            MB_ID:   rdata[ID_W-1:0] = q.mb[mb_idx].id;
            MB_STAT: begin
              rdata[MBS_READY] = q.mb[mb_idx].ready;
              rdata[MBS_LOST]  = q.mb[mb_idx].lost;
            end
            MB_DLO:  rdata = q.mb[mb_idx].dlo;
            MB_DHI:  rdata = q.mb[mb_idx].dhi;
            default: rdata = '0;
          endcase
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n           = q;
    n.proto_rst = 1'b0;
    n.pready    = acc_first;
    if (acc_first) begin
      n.prdata  = rdata;
      n.pslverr = !mapped;
    end
    // Error counters stay frozen in autobaud and sleep
    if (q.en && !q.autobaud_listen_bit && !q.sleep) begin
      n.tec = sat_step(q.tec, TEC_MAX, err_ev.tec_inc, err_ev.tec_dec);
      n.rec = 8'(sat_step({1'b0, q.rec}, REC_MAX, err_ev.rec_inc, err_ev.rec_dec));
    end
    if (wr_cyc && mapped) begin
      case (paddr)
        A_MODE: begin
          n.en  = pwdata[MODE_EN_BIT];
          n.autobaud_listen_bit = pwdata[MODE_ABM_BIT];
          n.lpm = pwdata[MODE_LPM_BIT];
          if (pwdata[MODE_EN_BIT] && !q.en) begin
            n.tec       = '0;
            n.rec       = '0;
            n.proto_rst = 1'b1;
            n.hunt      = 1'b1;
            n.wake      = 1'b0;
            n.sleep     = 1'b0;
          end
          if (!pwdata[MODE_EN_BIT]) begin
            n.hunt  = 1'b0;
            n.wake  = 1'b0;
            n.sleep = 1'b0;
          end else if (q.en && q.lpm && !pwdata[MODE_LPM_BIT]) begin
            n.hunt = 1'b1;
          end
        end
        A_IER:     n.imr = q.imr | (pwdata & IRQ_BITS);
        A_IDR:     n.imr = q.imr & ~pwdata;
        A_BITTIME: n.bittime = pwdata;
        A_IMR, A_STATUS, A_TIMER, A_TSTAMP, A_ERRCNT: n.imr = q.imr;
        default: begin
          case (mb_sub)
            MB_MODE: begin
              n.mb[mb_idx].otype = pwdata[MBM_OT_LSB +: 3];
              n.mb[mb_idx].prio  = pwdata[MBM_PR_LSB +: 4];
              if (pwdata[MBM_OT_LSB +: 3] == OT_RX || pwdata[MBM_OT_LSB +: 3] == OT_RXOW) begin
                n.mb[mb_idx].ready = 1'b0;
                n.mb[mb_idx].lost  = 1'b0;
              end
            end
            MB_MASK: n.mb[mb_idx].mask = pwdata[ID_W-1:0];
            MB_ID:   n.mb[mb_idx].id   = pwdata[ID_W-1:0];
            MB_DLO:  n.mb[mb_idx].dlo  = pwdata;
            MB_DHI:  n.mb[mb_idx].dhi  = pwdata;
            MB_CTRL: begin
              if (pwdata[MBC_XFER]) begin
                n.mb[mb_idx].ready = 1'b0;
              end
            end
            default: n.mb[mb_idx].lost = q.mb[mb_idx].lost;
          endcase
        end
      endcase
    end
    // Read side effects; later hardware sets override them
    if (rd_cyc && mb_hit && mb_sub == MB_STAT) begin
      n.mb[mb_idx].lost = 1'b0;
    end
    if (rd_cyc && paddr == A_STATUS) begin
      n.tovf = 1'b0;
      n.tstp = 1'b0;
    end
    // Free-running timer on the bit-time enable
    if (q.en && bit_tick) begin
      n.timer = q.timer + 16'h0001;
      if (q.timer == 16'hFFFF) begin
        n.tovf = 1'b1;
      end
    end
    if (q.en && frame_edge) begin
      n.tstamp = q.timer;
      n.tstp   = 1'b1;
    end
    // Low-power entry once transmit side has drained
    if (q.en && q.lpm && !tx_pending && !q.sleep) begin
      n.sleep = 1'b1;
      n.wake  = 1'b0;
      n.hunt  = 1'b0;
    end
    if (sync_pulse && q.en && q.hunt) begin
      n.wake  = 1'b1;
      n.sleep = 1'b0;
      n.hunt  = 1'b0;
    end
    // Frame delivery to mailboxes
    if (acc_hit) begin
      n.mb[acc_idx].dlo   = rx_frame.data[31:0];
      n.mb[acc_idx].dhi   = rx_frame.data[63:32];
      n.mb[acc_idx].ready = 1'b1;
      if (q.mb[acc_idx].ready) begin
        n.mb[acc_idx].lost = 1'b1;
      end
    end else if (rx_take) begin
      for (int i = 0; i < NUM_MB; i++) begin
        if (q.mb[i].otype == OT_RX && q.mb[i].ready && id_match(rx_frame.id, q.mb[i].id, q.mb[i].mask)) begin
          n.mb[i].lost = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.imr     <= IMR_RST;
      q.bittime <= BITTIME_RST;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr & q.pready;
  assign can_active  = q.en & q.wake & !q.sleep;
  assign proto_reset = q.proto_rst;
  assign bit_timing  = q.bittime;
  assign can_irq     = |(status & q.imr & IRQ_BITS);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_off_no_accept: assert property ((!q.en && rx_valid) |=> ((ready_vec & ~$past(ready_vec)) == '0))
    else $error("mailbox accepted a frame while disabled");
  a_enable_clears: assert property ((wr_cyc && paddr == A_MODE && pwdata[MODE_EN_BIT] && !q.en)
    |=> (q.tec == 9'h000 && q.rec == 8'h00 && proto_reset) ##1 !proto_reset)
    else $error("enable did not clear counters or pulse protocol reset");
  a_sync_wakes: assert property ((sync_pulse && q.en && q.hunt) |=> (q.wake && !q.sleep && !q.hunt))
    else $error("bus sync did not set wake flag");
  a_ier_unmask: assert property ((wr_cyc && paddr == A_IER)
    |=> ((q.imr & $past(pwdata) & IRQ_BITS) == ($past(pwdata) & IRQ_BITS)))
    else $error("interrupt enable write did not unmask");
  a_warn_level: assert property (warn |-> (erra && (q.tec > WARN_LIMIT || {1'b0, q.rec} > WARN_LIMIT)))
    else $error("warning flag without active state and high counter");
  a_stamp_copy: assert property ((q.en && frame_edge) |=> (q.tstamp == $past(q.timer) && q.tstp))
    else $error("timestamp not captured from timer");
  a_status_clear: assert property ((rd_cyc && paddr == A_STATUS && !frame_edge) |=> !q.tstp)
    else $error("timestamp flag survived status read");
  a_xfer_clears: assert property ((wr_cyc && mb_hit && mb_sub == MB_CTRL && pwdata[MBC_XFER] && !rx_valid)
    |=> !ready_vec[$past(mb_idx)])
    else $error("transfer command did not clear ready");
  a_keep_first: assert property ((rx_valid && q.mb[0].otype == OT_RX && q.mb[0].ready && !wr_cyc)
    |=> ($stable(q.mb[0].dlo) && $stable(q.mb[0].dhi)))
    else $error("plain receive mailbox overwritten");
endmodule
`default_nettype wire

// ==== design/cirm_pkg.sv ====
`default_nettype none
package cirm_pkg;
  localparam int          NUM_MB      = 4;
  localparam int          MB_IDX_W    = 2;
  localparam int          ID_W        = 29;
  // ------------------------------------------------------------
  // Global register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0]  A_MODE      = 8'h00;
  localparam logic [7:0]  A_IER       = 8'h04;
  localparam logic [7:0]  A_IDR       = 8'h08;
  localparam logic [7:0]  A_IMR       = 8'h0C;
  localparam logic [7:0]  A_STATUS    = 8'h10;
  localparam logic [7:0]  A_BITTIME   = 8'h14;
  localparam logic [7:0]  A_TIMER     = 8'h18;
  localparam logic [7:0]  A_TSTAMP    = 8'h1C;
  localparam logic [7:0]  A_ERRCNT    = 8'h20;
  // ------------------------------------------------------------
  // Mailbox window: base 0x40, stride 0x20, offsets inside it
  // ------------------------------------------------------------
  localparam logic [2:0]  MB_FIRST    = 3'h2;
  localparam logic [2:0]  MB_LAST     = 3'h5;
  localparam logic [4:0]  MB_MODE     = 5'h00;
  localparam logic [4:0]  MB_MASK     = 5'h04;
  localparam logic [4:0]  MB_ID       = 5'h08;
  localparam logic [4:0]  MB_STAT     = 5'h0C;
  localparam logic [4:0]  MB_DLO      = 5'h10;
  localparam logic [4:0]  MB_DHI      = 5'h14;
  localparam logic [4:0]  MB_CTRL     = 5'h18;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int          MODE_EN_BIT  = 0;
  localparam int          MODE_ABM_BIT = 1;
  localparam int          MODE_LPM_BIT = 2;
  localparam int          ST_ERRA     = 16;
  localparam int          ST_WARN     = 17;
  localparam int          ST_ERRP     = 18;
  localparam int          ST_BOFF     = 19;
  localparam int          ST_SLEEP    = 20;
  localparam int          ST_WAKE     = 21;
  localparam int          ST_TOVF     = 22;
  localparam int          ST_TSTP     = 23;
  localparam int          MBM_OT_LSB  = 24;
  localparam int          MBM_PR_LSB  = 16;
  localparam int          MBS_READY   = 23;
  localparam int          MBS_LOST    = 24;
  localparam int          MBC_XFER    = 23;
  localparam logic [31:0] IRQ_BITS    = 32'h00FF000F;
  localparam logic [2:0]  OT_RX       = 3'h1;
  localparam logic [2:0]  OT_RXOW     = 3'h2;
  // ------------------------------------------------------------
  // Reset values and limits
  // ------------------------------------------------------------
  localparam logic [31:0] IMR_RST     = 32'h00000000;
  localparam logic [31:0] BITTIME_RST = 32'h00000009;
  localparam logic [8:0]  WARN_LIMIT  = 9'h060;
  localparam logic [8:0]  PASS_LIMIT  = 9'h080;
  localparam logic [8:0]  TEC_MAX     = 9'h1FF;
  localparam logic [8:0]  REC_MAX     = 9'h0FF;
  localparam logic [3:0]  RECESSIVE_RUN = 4'hB;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [63:0]     data;
  } cirm_frame_type;

  typedef struct packed {
    logic tec_inc;
    logic tec_dec;
    logic rec_inc;
    logic rec_dec;
  } cirm_errev_type;

  typedef struct packed {
    logic [2:0]      otype;
    logic [3:0]      prio;
    logic [ID_W-1:0] mask;
    logic [ID_W-1:0] id;
    logic [31:0]     dlo;
    logic [31:0]     dhi;
    logic            ready;
    logic            lost;
  } cirm_mbox_type;

  typedef cirm_mbox_type [NUM_MB-1:0] cirm_mbox_arr_type;

  function automatic logic id_match(input logic [ID_W-1:0] a, input logic [ID_W-1:0] b,
                                    input logic [ID_W-1:0] m);
    return ((a ^ b) & m) == '0;
  endfunction
endpackage
`default_nettype wire

// ==== design/cirm_bus_sync.sv ====
`default_nettype none
module cirm_bus_sync (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        can_rx,
  input  wire logic [15:0] bit_cycles,
  input  wire logic        hunt,
  output logic             bit_tick,
  output logic             synced
);
  import cirm_pkg::*;

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [15:0] div;
    logic [3:0]  run;
    logic        tick;
    logic        synced;
  } cirm_sync_state_type;

  cirm_sync_state_type q;
  cirm_sync_state_type n;

  // ------------------------------------------------------------
  // Bit-time divider and recessive run counter
  // ------------------------------------------------------------
  always_comb begin
    n        = q;
    n.s1     = can_rx;
    n.s2     = q.s1;
    n.tick   = 1'b0;
    n.synced = 1'b0;
    if (q.div == 16'h0000) begin
      n.div  = bit_cycles;
      n.tick = 1'b1;
    end else begin
      n.div = q.div - 16'h0001;
    end
    if (!hunt) begin
      n.run = 4'h0;
    end else if (q.tick) begin
      if (!q.s2) begin
        n.run = 4'h0;
      end else if (q.run == RECESSIVE_RUN - 4'h1) begin
        n.run    = 4'h0;
        n.synced = 1'b1;
      end else begin
        n.run = q.run + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign bit_tick = q.tick;
  assign synced   = q.synced;
endmodule
`default_nettype wire

// ==== design/cirm_accept.sv ====
`default_nettype none
module cirm_accept (
  input  wire cirm_pkg::cirm_mbox_arr_type  mbx,
  input  wire logic [cirm_pkg::ID_W-1:0]    rx_id,
  input  wire logic                         active,
  output logic                              hit,
  output logic [cirm_pkg::MB_IDX_W-1:0]     idx
);
  import cirm_pkg::*;

  // ------------------------------------------------------------
  // Lowest-numbered eligible mailbox wins; priority ignored
  // ------------------------------------------------------------
  always_comb begin
    hit = 1'b0;
    idx = '0;
    for (int i = NUM_MB - 1; i >= 0; i--) begin
      if (active && id_match(rx_id, mbx[i].id, mbx[i].mask) &&
          (mbx[i].otype == OT_RXOW || (mbx[i].otype == OT_RX && !mbx[i].ready))) begin
        hit = 1'b1;
        idx = MB_IDX_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/cirm_bus_model.sv ====
`default_nettype none
module cirm_bus_model (
  input  wire logic               pclk,
  input  wire logic               send,
  input  wire cirm_pkg::cirm_frame_type frame_in,
  input  wire logic               mark,
  output logic                    can_rx,
  output cirm_pkg::cirm_frame_type rx_frame,
  output logic                    rx_valid,
  output logic                    frame_edge
);
  import cirm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Far-side node
  // ------------------------------------------------------------
  // Idle bus stays recessive so the controller can synchronise
  assign can_rx = 1'b1;
  initial begin
    rx_valid   = 1'b0;
    frame_edge = 1'b0;
    rx_frame   = '0;
  end
  // Frame lines toggle when no frame is offered
  always @(posedge pclk) begin
    rx_valid   <= send;
    frame_edge <= mark;
    rx_frame   <= send ? frame_in : ~rx_frame;
  end
endmodule
`default_nettype wire

// ==== verification/cirm_top_tb.sv ====
`default_nettype none
module cirm_top_tb;
  import cirm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, bit_timing, r;
  logic can_rx, rx_valid, frame_edge, can_active, proto_reset, can_irq, send, mark, e, pr, txp;
  cirm_frame_type rx_frame, fi;
  cirm_errev_type ev;
  int fail_count, n_compared, cyc;
  localparam logic [31:0] SS = 32'h00300000;
  localparam logic [31:0] RDY = 32'h00800000;
  localparam logic [31:0] LST = 32'h01000000;
  localparam logic [28:0] IDA = 29'h0ABC123;
  cirm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .can_rx(can_rx), .rx_frame(rx_frame), .rx_valid(rx_valid), .frame_edge(frame_edge),
    .err_ev(ev), .tx_pending(txp), .can_active(can_active), .proto_reset(proto_reset),
    .bit_timing(bit_timing), .can_irq(can_irq));
  cirm_bus_model bus (.pclk(pclk), .send(send), .frame_in(fi), .mark(mark), .can_rx(can_rx),
    .rx_frame(rx_frame), .rx_valid(rx_valid), .frame_edge(frame_edge));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    r = prdata;
    e = pslverr;
    pr = proto_reset;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(0, a, 0);
    check(nm, r & m, x);
  endtask
  function automatic logic [7:0] ma(input int n, input logic [4:0] o);
    return 8'h40 + 8'(n * 32) + {3'h0, o};
  endfunction
  task automatic tx(input logic [28:0] id, input logic [31:0] lo);
    fi <= {id, 32'h0, lo};
    send <= 1;
    @(posedge pclk);
    send <= 0;
    repeat (3) @(posedge pclk);
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, send, mark, presetn, txp, ev} = '0;
    fi = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    check("bit_timing", bit_timing, BITTIME_RST);
    check("active", {31'h0, can_active}, 0);
    rdc("imr", A_IMR, '1, IMR_RST);
    rdc("wake_sleep", A_STATUS, SS, 0);
    $display("test reset done");
    apb(1, A_BITTIME, 32'h1);
    apb(1, A_IER, IRQ_BITS);
    rdc("imr_set", A_IMR, '1, IRQ_BITS);
    apb(1, A_IDR, 32'h00FF000E);
    rdc("imr_clr", A_IMR, '1, 32'h1);
    apb(1, A_MODE, 32'h1);
    for (int i = 0; i < 200 && can_active !== 1'b1; i++) @(posedge pclk);
    rdc("errcnt", A_ERRCNT, '1, 0);
    rdc("wake", A_STATUS, SS, 32'h00200000);
    $display("test enable done");
    for (int i = 0; i < 2; i++) begin
      apb(1, ma(i, MB_MASK), {3'h0, {29{1'b1}}});
      apb(1, ma(i, MB_ID), {3'h0, IDA});
      apb(1, ma(i, MB_MODE), {5'h0, i ? OT_RXOW : OT_RX, 4'h0, i ? 4'h0 : 4'hF, 16'h0});
    end
    rdc("rdy0", ma(0, MB_STAT), RDY, 0);
    tx(IDA, 32'hA);
    rdc("rdy0", ma(0, MB_STAT), RDY, RDY);
    check("irq", {31'h0, can_irq}, 1);
    tx(IDA, 32'hB);
    rdc("dlo1", ma(1, MB_DLO), '1, 32'hB);
    tx(IDA, 32'hC);
    rdc("dlo0", ma(0, MB_DLO), '1, 32'hA);
    rdc("dlo1", ma(1, MB_DLO), '1, 32'hC);
    rdc("lost1", ma(1, MB_STAT), LST, LST);
    rdc("lost1", ma(1, MB_STAT), LST, 0);
    apb(1, ma(0, MB_CTRL), RDY);
    rdc("rdy0", ma(0, MB_STAT), RDY, 0);
    check("irq", {31'h0, can_irq}, 0);
    tx(IDA ^ 29'h10, 32'hD);
    rdc("rdy0", ma(0, MB_STAT), RDY, 0);
    apb(1, ma(1, MB_MODE), 0);
    tx(IDA, 32'hE);
    tx(IDA, 32'hF);
    rdc("lost0", ma(0, MB_STAT), LST | RDY, LST | RDY);
    rdc("dlo0", ma(0, MB_DLO), '1, 32'hE);
    $display("test mailboxes done");
    ev <= 4'hA;
    repeat (3) @(posedge pclk);
    ev <= 4'h8;
    repeat (97) @(posedge pclk);
    ev <= '0;
    rdc("errcnt_up", A_ERRCNT, '1, 32'h00640003);
    rdc("warn", A_STATUS, 32'h000F0000, 32'h00030000);
    apb(1, A_MODE, 32'h3);
    ev <= 4'hA;
    repeat (3) @(posedge pclk);
    ev <= '0;
    rdc("frozen", A_ERRCNT, '1, 32'h00640003);
    apb(1, ma(0, MB_CTRL), RDY);
    apb(1, A_MODE, 0);
    tx(IDA, 32'h5);
    rdc("rdy_off", ma(0, MB_STAT), RDY, 0);
    apb(1, A_MODE, 32'h1);
    check("proto_reset", {31'h0, pr}, 1);
    rdc("errcnt_clr", A_ERRCNT, '1, 0);
    for (int i = 0; i < 200 && can_active !== 1'b1; i++) @(posedge pclk);
    txp <= 1;
    apb(1, A_MODE, 32'h5);
    rdc("busy", A_STATUS, SS, 32'h00200000);
    txp <= 0;
    repeat (2) @(posedge pclk);
    rdc("sleep", A_STATUS, SS, 32'h00100000);
    apb(1, A_MODE, 32'h1);
    for (int i = 0; i < 200 && can_active !== 1'b1; i++) @(posedge pclk);
    rdc("rewake", A_STATUS, SS, 32'h00200000);
    $display("test errors and power done");
    mark <= 1;
    @(posedge pclk);
    mark <= 0;
    repeat (3) @(posedge pclk);
    rdc("tstamp", A_STATUS, 32'h00800000, 32'h00800000);
    rdc("tstamp", A_STATUS, 32'h00800000, 0);
    apb(0, 8'h30, 0);
    check("slverr", {31'h0, e}, 1);
    check("bad_rd", r, 0);
    $display("test status done");
    report_and_stop();
  end
endmodule
`default_nettype wire
